// ### fsh_service_handler.sv
// slave-side service handler: diagnosis, config check, global control, set-address
// assumes a receiver delivering decoded request telegrams, an apb master, and an
// nvm controller that raises nvm_busy while writing and presents stored contents
// How it works
// - act only on good sd1/sd2 requests to own station address
// - diagnosis answer is six header bytes plus seven external bytes
// - outside freeze, every diagnosis request renews the content; rsp_diag_new marks changed inputs
// - during freeze the captured content is resent until the next freeze or unfreeze
// - external header byte is always the constant seven
// - group byte is the inverted port e pin levels
// - reserved diagnosis bytes eight and eleven are always zero
// - bytes nine and ten are inverted ports c and d, zero without extension
// - set mask bits hide their channel pin errors; masks clear on reset
// - last byte bit 7 flags a failed nvm address write
// - last byte bit 6 is high while an nvm write runs
// - output code 20h..23h or a0h..a3h, none is 00h
// - input code 10h..13h or 90h..93h, none is zero
// - global control sync or freeze bits run output hold or input capture
// - set-address only in nvm address mode, otherwise negative answer
// - new station address must lie in 0..125
// - accepted address and lock flag are written to nvm and read back
// - failed programming falls back to address 126 and flags the fault
// - no set-address request is processed while programming runs
// - once locked, changes need the address-change-allow input high
// - after power-on one address overwrite is always allowed
// - read-inputs, read-outputs and get-config served on saps 56, 57, 59
//
// The placing of the registers and the APB interface to the registers were decided locally.
`include "fsh_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsh_service_handler
   import fsh_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic req_valid,
   input wire logic req_frame_ok,
   input wire logic [6:0] req_dest,
   input wire logic [5:0] req_sap,
   input wire logic [2:0] req_nbytes,
   input wire logic [7:0] req_byte0,
   input wire logic [7:0] req_byte1,
   input wire logic [7:0] diag_port_e,
   input wire logic [7:0] diag_port_c,
   input wire logic [7:0] diag_port_d,
   input wire logic addr_change_allow,
   input wire logic nvm_busy,
   input wire logic [6:0] nvm_rd_addr,
   input wire logic nvm_rd_lock,
   output logic rsp_valid,
   output fsh_rsp_e rsp_kind,
   output logic rsp_diag_new,
   output logic [7:0] rsp_byte,
   output logic rsp_byte_valid,
   output logic rsp_byte_last,
   output logic svc_busy,
   output logic [6:0] station_addr,
   output logic sync_active,
   output logic freeze_active,
   output logic sync_pulse,
   output logic freeze_pulse,
   output logic nvm_wr_start,
   output logic [6:0] nvm_wr_addr,
   output logic nvm_wr_lock
);
   // apb-visible configuration
   logic [2:0] cfg_out_cnt, next_cfg_out_cnt;
   logic [2:0] cfg_in_cnt, next_cfg_in_cnt;
   logic cfg_ext_diag, next_cfg_ext_diag;
   logic cfg_addr_nvm, next_cfg_addr_nvm;
   logic [7:0] mask_c, next_mask_c;
   logic [7:0] mask_d, next_mask_d;
   logic [31:0] hdr_a, next_hdr_a;
   logic [15:0] hdr_b, next_hdr_b;
   logic lock_flag, next_lock_flag;
   logic first_chg_ok, next_first_chg_ok;
   logic cfg_ok, next_cfg_ok;
   logic prog_fault, next_prog_fault;
   logic [31:0] next_prdata;
   logic next_pready, next_pslverr;
   logic [6:0] next_station_addr;
   logic next_sync_active, next_freeze_active, next_sync_pulse, next_freeze_pulse;
   // diagnosis snapshot (bytes 7, 9, 10)
   logic [23:0] diag_snap, next_diag_snap;
   logic [23:0] diag_live;
   logic diag_new, next_diag_new;
   // response path
   fsh_tx_e tx_state, next_tx_state;
   logic [3:0] tx_idx, next_tx_idx;
   logic next_rsp_valid, next_rsp_diag_new, next_rsp_byte_valid, next_rsp_byte_last;
   fsh_rsp_e next_rsp_kind;
   logic [7:0] next_rsp_byte, tx_mux;
   // nvm programming
   fsh_nv_e nv_state, next_nv_state;
   logic next_nvm_wr_start, next_nvm_wr_lock;
   logic [6:0] next_nvm_wr_addr;
   logic apb_wr, apb_setup, req_take;
   logic [7:0] out_code, in_code;

   assign apb_setup = psel & ~penable;
   assign apb_wr = psel & penable & pready & pwrite;
   // own-address filter; other frames are dropped silently
   assign req_take = req_valid & req_frame_ok & (req_dest == station_addr) & ~svc_busy;

   // inverted pins, masked channel errors, channel bytes only with extension
   assign diag_live = {~diag_port_e,
                       cfg_ext_diag ? (~diag_port_c & ~mask_c) : 8'h00,
                       cfg_ext_diag ? (~diag_port_d & ~mask_d) : 8'h00};

   assign out_code = (cfg_out_cnt == 3'h0) ? 8'h00
                   : (`FSH_OUT_CODE | {6'h00, cfg_out_cnt[1:0] - 2'h1});
   assign in_code = (cfg_in_cnt == 3'h0) ? 8'h00
                  : (`FSH_IN_CODE | {6'h00, cfg_in_cnt[1:0] - 2'h1});

   // apb slave: zero-wait, answer registered in the setup cycle
   always_comb begin
      next_pready = apb_setup;
      next_pslverr = 1'b0;
      next_prdata = 32'h0000_0000;
      if (apb_setup) begin
         unique case (paddr)
            `FSH_OFF_CFG: next_prdata = {22'h0, cfg_addr_nvm, cfg_ext_diag, 1'b0, cfg_in_cnt,
                                         1'b0, cfg_out_cnt};
            `FSH_OFF_MASK: next_prdata = {16'h0, mask_d, mask_c};
            `FSH_OFF_HDRA: next_prdata = hdr_a;
            `FSH_OFF_HDRB: next_prdata = {16'h0, hdr_b};
            `FSH_OFF_ADDR: next_prdata = {23'h0, lock_flag, 1'b0, station_addr};
            `FSH_OFF_STAT: next_prdata = {17'h0, first_chg_ok, cfg_ok, sync_active, freeze_active,
                                          prog_fault, (nv_state != fsh_nv_idle), lock_flag,
                                          1'b0, station_addr};
            default: next_pslverr = 1'b1;
         endcase
      end
   end

   // software configuration writes
   always_comb begin
      next_cfg_out_cnt = cfg_out_cnt;
      next_cfg_in_cnt = cfg_in_cnt;
      next_cfg_ext_diag = cfg_ext_diag;
      next_cfg_addr_nvm = cfg_addr_nvm;
      next_mask_c = mask_c;
      next_mask_d = mask_d;
      next_hdr_a = hdr_a;
      next_hdr_b = hdr_b;
      if (apb_wr) begin
         unique case (paddr)
            `FSH_OFF_CFG: begin
               next_cfg_out_cnt = pwdata[2:0];
               next_cfg_in_cnt = pwdata[6:4];
               next_cfg_ext_diag = pwdata[8];
               next_cfg_addr_nvm = pwdata[9];
            end
            `FSH_OFF_MASK: begin
               next_mask_c = pwdata[7:0];
               next_mask_d = pwdata[15:8];
            end
            `FSH_OFF_HDRA: next_hdr_a = pwdata;
            `FSH_OFF_HDRB: next_hdr_b = pwdata[15:0];
            default: ;
         endcase
      end
   end

   // request decode and global control
   always_comb begin
      next_rsp_valid = 1'b0;
      next_rsp_kind = rsp_kind;
      next_rsp_diag_new = rsp_diag_new;
      next_cfg_ok = cfg_ok;
      next_sync_active = sync_active;
      next_freeze_active = freeze_active;
      next_sync_pulse = 1'b0;
      next_freeze_pulse = 1'b0;
      next_diag_snap = diag_snap;
      next_diag_new = diag_new;
      next_tx_state = tx_state;
      next_nv_state = nv_state;
      next_nvm_wr_start = 1'b0;
      next_nvm_wr_addr = nvm_wr_addr;
      next_nvm_wr_lock = nvm_wr_lock;
      next_station_addr = station_addr;
      next_lock_flag = lock_flag;
      next_first_chg_ok = first_chg_ok;
      next_prog_fault = prog_fault;
      if (apb_wr && paddr == `FSH_OFF_STAT && pwdata[`FSH_STAT_FAULT_BIT]) begin
         next_prog_fault = 1'b0;
      end
      if (apb_wr && paddr == `FSH_OFF_ADDR) begin
         next_station_addr = pwdata[6:0];
         next_lock_flag = pwdata[8];
      end
      if (!freeze_active && diag_live != diag_snap) begin
         next_diag_new = 1'b1;
      end
      if (req_take) begin
         unique case (req_sap)
            `FSH_SAP_DIAG: begin
               next_rsp_valid = 1'b1;
               next_rsp_kind = fsh_rsp_diag;
               next_tx_state = fsh_tx_diag;
               next_rsp_diag_new = diag_new & ~freeze_active;
               if (!freeze_active) begin
                  next_diag_snap = diag_live;
                  next_diag_new = 1'b0;
               end
            end
            `FSH_SAP_CHKCFG: begin
               next_rsp_valid = 1'b1;
               // consistency bit is free unless the code is zero; bits 6..0 must match exactly
               if (req_nbytes == `FSH_CFG_NBYTES
                   && {1'b0, req_byte0[6:0]} == {1'b0, out_code[6:0]}
                   && {1'b0, req_byte1[6:0]} == {1'b0, in_code[6:0]}
                   && (out_code != 8'h00 || !req_byte0[`FSH_CONSIST_BIT])
                   && (in_code != 8'h00 || !req_byte1[`FSH_CONSIST_BIT])) begin
                  next_rsp_kind = fsh_rsp_ack;
                  next_cfg_ok = 1'b1;
               end else begin
                  next_rsp_kind = fsh_rsp_cfg_fault;
                  next_cfg_ok = 1'b0;
               end
            end
            `FSH_SAP_GLOBAL: begin
               if (req_byte0[`FSH_GC_SYNC]) begin
                  next_sync_active = 1'b1;
                  next_sync_pulse = 1'b1;
               end else if (req_byte0[`FSH_GC_UNSYNC]) begin
                  next_sync_active = 1'b0;
               end
               if (req_byte0[`FSH_GC_FREEZE]) begin
                  next_freeze_active = 1'b1;
                  next_freeze_pulse = 1'b1;
                  next_diag_snap = diag_live;
                  next_diag_new = 1'b0;
               end else if (req_byte0[`FSH_GC_UNFREEZE]) begin
                  next_freeze_active = 1'b0;
               end
            end
            `FSH_SAP_RDINP, `FSH_SAP_RDOUTP: begin
               next_rsp_valid = 1'b1;
               next_rsp_kind = fsh_rsp_data;
            end
            `FSH_SAP_GETCFG: begin
               next_rsp_valid = 1'b1;
               next_rsp_kind = fsh_rsp_data;
               next_tx_state = fsh_tx_cfg;
            end
            `FSH_SAP_SETADD: begin
               // a request during programming is dropped with no answer
               if (nv_state == fsh_nv_idle) begin
                  next_rsp_valid = 1'b1;
                  if (!cfg_addr_nvm
                      || req_byte0[7] || req_byte0[6:0] > `FSH_ADDR_MAX
                      || (lock_flag && !first_chg_ok && !addr_change_allow)) begin
                     next_rsp_kind = fsh_rsp_nak;
                  end else begin
                     next_rsp_kind = fsh_rsp_ack;
                     next_first_chg_ok = 1'b0;
                     next_nvm_wr_addr = req_byte0[6:0];
                     next_nvm_wr_lock = req_byte1[0];
                     next_nv_state = fsh_nv_write;
                  end
               end
            end
            default: ;
         endcase
      end
      // response byte stream
      if (tx_state != fsh_tx_idle && rsp_byte_last) begin
         next_tx_state = fsh_tx_idle;
      end
      // nvm write, wait for busy to drop, then compare the read-back
      unique case (nv_state)
         fsh_nv_idle: ;
         fsh_nv_write: begin
            next_nvm_wr_start = 1'b1;
            next_nv_state = fsh_nv_wait;
         end
         fsh_nv_wait: begin
            if (!nvm_busy && !nvm_wr_start) begin
               next_nv_state = fsh_nv_check;
            end
         end
         fsh_nv_check: begin
            next_nv_state = fsh_nv_idle;
            if (nvm_rd_addr == nvm_wr_addr && nvm_rd_lock == nvm_wr_lock) begin
               next_station_addr = nvm_wr_addr;
               next_lock_flag = nvm_wr_lock;
            end else begin
               next_station_addr = `FSH_ADDR_DEFAULT;
               next_prog_fault = 1'b1;
            end
         end
      endcase
   end

   always_comb begin
      tx_mux = 8'h00;
      if (tx_state == fsh_tx_cfg) begin
         tx_mux = (tx_idx == 4'h0) ? out_code : in_code;
      end else begin
         unique case (tx_idx)
            4'h0, 4'h1, 4'h2, 4'h3: tx_mux = hdr_a[{tx_idx[1:0], 3'h0} +: 8];
            4'h4, 4'h5: tx_mux = hdr_b[{tx_idx[0], 3'h0} +: 8];
            `FSH_DIAG_HDR_IDX: tx_mux = `FSH_DIAG_HDR;
            `FSH_DIAG_GRP_IDX: tx_mux = diag_snap[23:16];
            `FSH_DIAG_C_IDX: tx_mux = diag_snap[15:8];
            `FSH_DIAG_D_IDX: tx_mux = diag_snap[7:0];
            `FSH_DIAG_NVM_IDX: tx_mux = {prog_fault, nv_state != fsh_nv_idle, 6'h00};
            default: tx_mux = 8'h00;
         endcase
      end
   end

   always_comb begin
      next_tx_idx = 4'h0;
      next_rsp_byte_valid = 1'b0;
      next_rsp_byte_last = 1'b0;
      next_rsp_byte = 8'h00;
      if (tx_state != fsh_tx_idle && !rsp_byte_last) begin
         next_rsp_byte_valid = 1'b1;
         next_rsp_byte = tx_mux;
         next_tx_idx = tx_idx + 4'h1;
         next_rsp_byte_last = (tx_state == fsh_tx_cfg) ? (tx_idx == 4'h1)
                                                       : (tx_idx == `FSH_DIAG_LAST);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         cfg_out_cnt <= 3'h0;
         cfg_in_cnt <= 3'h0;
         cfg_ext_diag <= 1'b0;
         cfg_addr_nvm <= 1'b0;
         mask_c <= 8'h00;
         mask_d <= 8'h00;
         hdr_a <= 32'h0000_0000;
         hdr_b <= 16'h0000;
         lock_flag <= 1'b0;
         first_chg_ok <= 1'b1;
         cfg_ok <= 1'b0;
         prog_fault <= 1'b0;
         station_addr <= `FSH_ADDR_DEFAULT;
         sync_active <= 1'b0;
         freeze_active <= 1'b0;
         sync_pulse <= 1'b0;
         freeze_pulse <= 1'b0;
         diag_snap <= 24'h000000;
         diag_new <= 1'b0;
         tx_state <= fsh_tx_idle;
         tx_idx <= 4'h0;
         rsp_valid <= 1'b0;
         rsp_kind <= fsh_rsp_ack;
         rsp_diag_new <= 1'b0;
         rsp_byte <= 8'h00;
         rsp_byte_valid <= 1'b0;
         rsp_byte_last <= 1'b0;
         svc_busy <= 1'b0;
         nv_state <= fsh_nv_idle;
         nvm_wr_start <= 1'b0;
         nvm_wr_addr <= 7'h00;
         nvm_wr_lock <= 1'b0;
      end else begin
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
         cfg_out_cnt <= next_cfg_out_cnt;
         cfg_in_cnt <= next_cfg_in_cnt;
         cfg_ext_diag <= next_cfg_ext_diag;
         cfg_addr_nvm <= next_cfg_addr_nvm;
         mask_c <= next_mask_c;
         mask_d <= next_mask_d;
         hdr_a <= next_hdr_a;
         hdr_b <= next_hdr_b;
         lock_flag <= next_lock_flag;
         first_chg_ok <= next_first_chg_ok;
         cfg_ok <= next_cfg_ok;
         prog_fault <= next_prog_fault;
         station_addr <= next_station_addr;
         sync_active <= next_sync_active;
         freeze_active <= next_freeze_active;
         sync_pulse <= next_sync_pulse;
         freeze_pulse <= next_freeze_pulse;
         diag_snap <= next_diag_snap;
         diag_new <= next_diag_new;
         tx_state <= next_tx_state;
         tx_idx <= next_tx_idx;
         rsp_valid <= next_rsp_valid;
         rsp_kind <= next_rsp_kind;
         rsp_diag_new <= next_rsp_diag_new;
         rsp_byte <= next_rsp_byte;
         rsp_byte_valid <= next_rsp_byte_valid;
         rsp_byte_last <= next_rsp_byte_last;
         // refuse requests while an answer stream is pending or running
         svc_busy <= (next_tx_state != fsh_tx_idle);
         nv_state <= next_nv_state;
         nvm_wr_start <= next_nvm_wr_start;
         nvm_wr_addr <= next_nvm_wr_addr;
         nvm_wr_lock <= next_nvm_wr_lock;
      end
   end
endmodule
`default_nettype wire

// ### fsh_defines.svh
// constants of the fieldbus slave service handler: apb map, field positions, codes
// assumes inclusion by bare name from the top module, the checker and the bench
`ifndef FSH_DEFINES_SVH
`define FSH_DEFINES_SVH
`define FSH_OFF_CFG 8'h00
`define FSH_OFF_MASK 8'h04
`define FSH_OFF_HDRA 8'h08
`define FSH_OFF_HDRB 8'h0c
`define FSH_OFF_ADDR 8'h10
`define FSH_OFF_STAT 8'h14
`define FSH_SAP_SETADD 6'h37
`define FSH_SAP_RDINP 6'h38
`define FSH_SAP_RDOUTP 6'h39
`define FSH_SAP_GLOBAL 6'h3a
`define FSH_SAP_GETCFG 6'h3b
`define FSH_SAP_DIAG 6'h3c
`define FSH_SAP_CHKCFG 6'h3e
`define FSH_GC_SYNC 5
`define FSH_GC_UNSYNC 4
`define FSH_GC_FREEZE 3
`define FSH_GC_UNFREEZE 2
`define FSH_DIAG_HDR 8'h07
`define FSH_DIAG_LAST 4'hc
`define FSH_DIAG_HDR_IDX 4'h6
`define FSH_DIAG_GRP_IDX 4'h7
`define FSH_DIAG_C_IDX 4'h9
`define FSH_DIAG_D_IDX 4'ha
`define FSH_DIAG_NVM_IDX 4'hc
`define FSH_OUT_CODE 8'h20
`define FSH_IN_CODE 8'h10
`define FSH_CONSIST_BIT 7
`define FSH_CFG_NBYTES 3'h2
`define FSH_ADDR_MAX 7'h7d
`define FSH_ADDR_DEFAULT 7'h7e
`define FSH_STAT_FAULT_BIT 10
`endif

// ### fsh_pkg.sv
// types of the fieldbus slave service handler
// assumes fsh_defines.svh is on the include path
package fsh_pkg;
   typedef enum logic [2:0] {
      fsh_rsp_ack, fsh_rsp_nak, fsh_rsp_cfg_fault, fsh_rsp_diag, fsh_rsp_data
   } fsh_rsp_e;
   typedef enum logic [1:0] {fsh_tx_idle, fsh_tx_diag, fsh_tx_cfg} fsh_tx_e;
   typedef enum logic [1:0] {fsh_nv_idle, fsh_nv_write, fsh_nv_wait, fsh_nv_check} fsh_nv_e;
endpackage

// ### fsh_chk.sv
// port assertions for the fieldbus slave service handler
// assumes a bind onto fsh_service_handler, a single pclk domain
`include "fsh_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fsh_chk
   import fsh_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic req_valid,
   input wire logic req_frame_ok,
   input wire logic [6:0] req_dest,
   input wire logic [5:0] req_sap,
   input wire logic nvm_busy,
   input wire logic rsp_valid,
   input wire fsh_rsp_e rsp_kind,
   input wire logic [7:0] rsp_byte,
   input wire logic rsp_byte_valid,
   input wire logic rsp_byte_last,
   input wire logic svc_busy,
   input wire logic [6:0] station_addr,
   input wire logic nvm_wr_start,
   input wire logic [6:0] nvm_wr_addr
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic [3:0] cnt;
   logic [3:0] next_cnt;
   logic hit;
   logic d_byte;
   assign hit = req_valid && req_frame_ok && req_dest == station_addr && !svc_busy;
   assign d_byte = rsp_byte_valid && rsp_kind == fsh_rsp_diag;
   // byte index restarts with each answer
   always_comb begin
      next_cnt = rsp_valid ? 4'h0 : cnt + {3'h0, rsp_byte_valid};
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt <= 4'h0;
      else cnt <= next_cnt;
   end
   sequence s_head;
      rsp_byte_valid [*8];
   endsequence
   sequence s_tail;
      rsp_byte_valid [*4] ##1 (rsp_byte_valid && rsp_byte_last);
   endsequence
   a_diag_frame: assert property (rsp_valid && rsp_kind == fsh_rsp_diag |=> s_head ##1 s_tail)
      else $error("diag stream shape wrong");
   a_diag_answer: assert property (hit && req_sap == `FSH_SAP_DIAG |=> rsp_valid && rsp_kind == fsh_rsp_diag)
      else $error("diag request not answered");
   a_foreign_drop: assert property (req_valid && (!req_frame_ok || req_dest != station_addr) |=> !rsp_valid)
      else $error("foreign request answered");
   a_hdr_const: assert property (d_byte && cnt == `FSH_DIAG_HDR_IDX |-> rsp_byte == `FSH_DIAG_HDR)
      else $error("diag header byte wrong");
   a_resv_zero: assert property (d_byte && (cnt == 4'h8 || cnt == 4'hb) |-> rsp_byte == 8'h00)
      else $error("reserved diag byte not zero");
   a_nvm_byte: assert property (d_byte && cnt == `FSH_DIAG_NVM_IDX |-> rsp_byte[5:0] == 6'h00 && rsp_byte_last)
      else $error("nvm diag byte wrong");
   a_active_bit: assert property (d_byte && cnt == `FSH_DIAG_NVM_IDX && nvm_busy |-> rsp_byte[6])
      else $error("programming active bit low");
   a_prog_start: assert property (nvm_wr_start |-> $past(rsp_valid, 1) && rsp_kind == fsh_rsp_ack)
      else $error("nvm write without accepted request");
   a_addr_range: assert property (nvm_wr_start |-> nvm_wr_addr <= `FSH_ADDR_MAX)
      else $error("out of range address written");
   a_busy_drop: assert property (hit && req_sap == `FSH_SAP_SETADD && nvm_busy |=> !rsp_valid)
      else $error("set-address served while programming");
endmodule
bind fsh_service_handler fsh_chk fsh_chk_i (.pclk, .presetn, .req_valid, .req_frame_ok,
   .req_dest, .req_sap, .nvm_busy, .rsp_valid, .rsp_kind, .rsp_byte, .rsp_byte_valid,
   .rsp_byte_last, .svc_busy, .station_addr, .nvm_wr_start, .nvm_wr_addr);
`default_nettype wire

// ### fsh_nvm_model.sv
// nvm model: stores address and lock flag, busy for BUSY_CYC cycles per write
// assumes nvm_wr_addr and nvm_wr_lock are held with the nvm_wr_start pulse
`timescale 1ns/1ps
`default_nettype none
module fsh_nvm_model #(parameter int BUSY_CYC = 30) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic nvm_wr_start,
   input wire logic [6:0] nvm_wr_addr,
   input wire logic nvm_wr_lock,
   input wire logic bad_write,
   output logic nvm_busy,
   output logic [6:0] nvm_rd_addr,
   output logic nvm_rd_lock
);
   int left;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         left <= 0;
         nvm_busy <= 1'b0;
         nvm_rd_addr <= 7'h05;
         nvm_rd_lock <= 1'b0;
      end else if (nvm_wr_start) begin
         left <= BUSY_CYC;
         nvm_busy <= 1'b1;
         // a bad cell keeps the inverse, which only a readback compare can catch
         nvm_rd_addr <= bad_write ? ~nvm_wr_addr : nvm_wr_addr;
         nvm_rd_lock <= nvm_wr_lock;
      end else if (left > 0) begin
         left <= left - 1;
         nvm_busy <= left > 1;
      end
   end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench: apb set-up, then request telegrams with expected answers
// assumes fsh_chk is bound in and fsh_nvm_model stands for the memory
`include "fsh_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import fsh_pkg::*;
;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, b0 = 8'h00, b1 = 8'h00, pe = 8'hf0, pc = 8'h0f, pd = 8'hfe;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, rv = 1'b0, fok = 1'b1, aca = 1'b0, bad = 1'b0, nw;
   logic [6:0] dst = 7'h00, st, wa, ra;
   logic [5:0] sap = 6'h00;
   logic [2:0] nb = 3'h0;
   logic busy, rl, wl, ws, rsv, rdn, bv, bl, sb, sa, fa, sp, fp;
   logic [7:0] rb;
   logic [7:0] q[$];
   fsh_rsp_e kind;
   int failures = 0, n_compared = 0, n_rsp = 0, n, n_pls = 0;
   logic [23:0] cc [6] = '{24'h221100, 24'h220102, 24'h221002, 24'h210212, 24'h121102,
      24'h2a1900};
   always #25 pclk = ~pclk;
   fsh_service_handler fsh_service_handler_i (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid(rv), .req_frame_ok(fok),
      .req_dest(dst), .req_sap(sap), .req_nbytes(nb), .req_byte0(b0), .req_byte1(b1),
      .diag_port_e(pe), .diag_port_c(pc), .diag_port_d(pd), .addr_change_allow(aca),
      .nvm_busy(busy), .nvm_rd_addr(ra), .nvm_rd_lock(rl), .rsp_valid(rsv), .rsp_kind(kind),
      .rsp_diag_new(rdn), .rsp_byte(rb), .rsp_byte_valid(bv), .rsp_byte_last(bl),
      .svc_busy(sb), .station_addr(st), .sync_active(sa), .freeze_active(fa),
      .sync_pulse(sp), .freeze_pulse(fp), .nvm_wr_start(ws), .nvm_wr_addr(wa),
      .nvm_wr_lock(wl));
   fsh_nvm_model fsh_nvm_model_i (.pclk, .presetn, .nvm_wr_start(ws), .nvm_wr_addr(wa),
      .nvm_wr_lock(wl), .bad_write(bad), .nvm_busy(busy), .nvm_rd_addr(ra), .nvm_rd_lock(rl));
   always @(posedge pclk) begin
      if (bv) q.push_back(rb);
      if (rsv) n_rsp++;
      if (rsv) nw = rdn;
      if (sp || fp) n_pls++;
   end
   task automatic wrap_up();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic limit(input int i);
      if (i >= 80) begin
         failures++;
         wrap_up();
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (i = 0; i < 80 && pready !== 1'b1; i++) @(posedge pclk);
      limit(i);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic svc(input logic [6:0] d, input logic [5:0] s, input logic [2:0] k,
      input logic [7:0] x, input logic [7:0] y);
      int i;
      q.delete();
      @(posedge pclk);
      {dst, sap, nb, b0, b1} <= {d, s, k, x, y};
      rv <= 1'b1;
      @(posedge pclk);
      rv <= 1'b0;
      repeat (2) @(posedge pclk);
      for (i = 0; i < 80 && sb !== 1'b0; i++) @(posedge pclk);
      limit(i);
   endtask
   task automatic diag(input logic [7:0] g, input logic [7:0] c, input logic [7:0] e,
      input logic [7:0] v);
      logic [7:0] x [13];
      svc(st, `FSH_SAP_DIAG, 3'h0, 8'h00, 8'h00);
      x = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, g, 8'h00, c, e, 8'h00, v};
      chk("diag count", 13, q.size());
      foreach (x[k]) chk("diag byte", x[k], q[k]);
   endtask
   task automatic wait_st(input logic [6:0] a);
      int i;
      for (i = 0; i < 80 && st !== a; i++) @(posedge pclk);
      limit(i);
      chk("station", a, st);
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `FSH_OFF_STAT, 0);
      chk("status", 32'h407e, rd);
      apb(0, `FSH_OFF_MASK, 0);
      chk("mask", 0, rd);
      apb(0, 8'h20, 0);
      chk("unmapped err", 1, err);
      apb(1, `FSH_OFF_CFG, 32'h312);
      apb(1, `FSH_OFF_ADDR, 32'h5);
      apb(1, `FSH_OFF_HDRA, 32'h04030201);
      apb(1, `FSH_OFF_HDRB, 32'h0605);
      diag(8'h0f, 8'hf0, 8'h01, 8'h00);
      chk("new", 1, nw);
      diag(8'h0f, 8'hf0, 8'h01, 8'h00);
      chk("new", 0, nw);
      pe <= 8'hee;
      diag(8'h11, 8'hf0, 8'h01, 8'h00);
      chk("new", 1, nw);
      n = n_rsp;
      svc(7'h06, `FSH_SAP_DIAG, 3'h0, 8'h00, 8'h00);
      fok <= 1'b0;
      svc(7'h05, `FSH_SAP_DIAG, 3'h0, 8'h00, 8'h00);
      fok <= 1'b1;
      chk("ignored", n, n_rsp);
      apb(1, `FSH_OFF_MASK, 32'h0130);
      diag(8'h11, 8'hc0, 8'h00, 8'h00);
      apb(1, `FSH_OFF_CFG, 32'h212);
      diag(8'h11, 8'h00, 8'h00, 8'h00);
      apb(1, `FSH_OFF_CFG, 32'h312);
      $display("diag test done");
      foreach (cc[k]) begin
         svc(st, `FSH_SAP_CHKCFG, cc[k][22:20], cc[k][19:12], cc[k][11:4]);
         chk("cfg kind", cc[k][3:0], kind);
      end
      svc(st, `FSH_SAP_GETCFG, 3'h0, 8'h00, 8'h00);
      chk("getcfg", 32'h42110, {kind, q[0], q[1]});
      svc(st, `FSH_SAP_RDINP, 3'h0, 8'h00, 8'h00);
      chk("rdinp", fsh_rsp_data, kind);
      svc(st, `FSH_SAP_RDOUTP, 3'h0, 8'h00, 8'h00);
      chk("rdoutp", fsh_rsp_data, kind);
      $display("config test done");
      svc(st, `FSH_SAP_GLOBAL, 3'h1, 8'h20, 8'h00);
      svc(st, `FSH_SAP_GLOBAL, 3'h1, 8'h08, 8'h00);
      chk("sync freeze", 2'b11, {sa, fa});
      pe <= 8'h7e;
      diag(8'h11, 8'hc0, 8'h00, 8'h00);
      svc(st, `FSH_SAP_GLOBAL, 3'h1, 8'h08, 8'h00);
      diag(8'h81, 8'hc0, 8'h00, 8'h00);
      svc(st, `FSH_SAP_GLOBAL, 3'h1, 8'h14, 8'h00);
      chk("released", 32'h3, {sa, fa, n_pls[29:0]});
      $display("global test done");
      svc(st, `FSH_SAP_SETADD, 3'h2, 8'h09, 8'h01);
      chk("setadd kind", fsh_rsp_ack, kind);
      diag(8'h81, 8'hc0, 8'h00, 8'h40);
      n = n_rsp;
      svc(st, `FSH_SAP_SETADD, 3'h2, 8'h0a, 8'h00);
      chk("busy drop", n, n_rsp);
      wait_st(7'h09);
      svc(st, `FSH_SAP_SETADD, 3'h2, 8'h0b, 8'h00);
      chk("locked", fsh_rsp_nak, kind);
      aca <= 1'b1;
      bad <= 1'b1;
      svc(st, `FSH_SAP_SETADD, 3'h2, 8'h0c, 8'h00);
      chk("allowed", fsh_rsp_ack, kind);
      wait_st(`FSH_ADDR_DEFAULT);
      diag(8'h81, 8'hc0, 8'h00, 8'h80);
      bad <= 1'b0;
      svc(st, `FSH_SAP_SETADD, 3'h2, 8'h7e, 8'h00);
      repeat (40) @(posedge pclk);
      chk("range", `FSH_ADDR_DEFAULT, st);
      apb(1, `FSH_OFF_CFG, 32'h112);
      svc(st, `FSH_SAP_SETADD, 3'h2, 8'h03, 8'h00);
      chk("shift mode", fsh_rsp_nak, kind);
      $display("set-address test done");
      wrap_up();
   end
endmodule
`default_nettype wire
